// file: logic/ssw_pkg.sv
// Constants shared by the supply supervisor and watchdog.
// Assumes a single 250 MHz logic clock and millivolt-coded supply samples.
package ssw_pkg;
  // Clock rate and documented times in microseconds.
  localparam int CLK_MHZ       = 250;
  localparam int SETUP_US      = 150;
  localparam int RST_MIN_US    = 25;
  localparam int WD_MIN_US     = 200;
  // Timing slopes: 2 us and 20 us per picofarad of timing capacitance.
  localparam int RST_US_PER_PF = 2;
  localparam int WD_US_PER_PF  = 20;
  localparam int SETUP_CYC     = SETUP_US * CLK_MHZ;
  localparam int RST_MIN_CYC   = RST_MIN_US * CLK_MHZ;
  localparam int WD_MIN_CYC    = WD_MIN_US * CLK_MHZ;
  localparam int RST_CYC_PF    = RST_US_PER_PF * CLK_MHZ;
  localparam int WD_CYC_PF     = WD_US_PER_PF * CLK_MHZ;

  // Register byte offsets.
  localparam logic [7:0] ADR_CTRL    = 8'h00;
  localparam logic [7:0] ADR_RST_CAP = 8'h04;
  localparam logic [7:0] ADR_WD_CAP  = 8'h08;
  localparam logic [7:0] ADR_STATUS  = 8'h0C;
  localparam logic [7:0] ADR_IRQ_ST  = 8'h10;
  localparam logic [7:0] ADR_IRQ_CLR = 8'h14;
  localparam logic [7:0] ADR_IRQ_EN  = 8'h18;

  // Field positions and reset values.
  localparam int CTRL_WD_GND   = 0;
  localparam int ST_RESET_N    = 0;
  localparam int ST_FAULT_N    = 1;
  localparam int ST_CONFIGURED = 2;
  localparam int ST_GOOD_LSB   = 8;
  localparam int ST_MODE_LSB   = 16;
  localparam int EV_RST_ASSERT = 0;
  localparam int EV_WD_FAULT   = 1;
  localparam int EV_RST_FREE   = 2;
  localparam int EV_DROP       = 3;
  localparam int NUM_EV        = 4;
  localparam logic [15:0] CAP_RESET = 16'h0000;

  // Thresholds in millivolts; adjustable inputs trip at 0.5 V, a negative one at 0 V.
  localparam logic [15:0] MV_5000 = 16'h1388;
  localparam logic [15:0] MV_3300 = 16'h0CE4;
  localparam logic [15:0] MV_3000 = 16'h0BB8;
  localparam logic [15:0] MV_2500 = 16'h09C4;
  localparam logic [15:0] MV_1800 = 16'h0708;
  localparam logic [15:0] MV_1500 = 16'h05DC;
  localparam logic [15:0] MV_HALF = 16'h01F4;
  localparam logic [15:0] MV_NEG  = 16'h0000;
  // Modes in which input four is a negative adjustable input.
  localparam logic [15:0] NEG_MODES = 16'h300A;

  typedef enum logic [1:0] {
    SSW_SETUP, SSW_HOLD, SSW_DELAY, SSW_RUN
  } ssw_state_t;
endpackage

// file: logic/ssw_supervisor.sv
// Six-input supply supervisor with common reset and watchdog, Wishbone regs.
// Assumes inputs synchronous to clk_i; supplies given as signed millivolts.
// How it works
// (R1) Each good output mirrors its input being above its threshold, or below 0 V for a negative input.
// (R2) Reset low on any bad input, held for the delay after recovery.
// (R3) Reset delay is 25 us plus 2 us per picofarad programmed.
// (R4) Watchdog period is 200 us plus 20 us per picofarad programmed.
// (R5) Watchdog runs only while reset is high, cleared otherwise.
// (R6) Watchdog expiry drives fault low for one reset delay.
// (R7) Fault returns high at once on a kick edge or reset low.
// (R8) Unserviced watchdog makes the fault output toggle forever.
// (R9) Either kick edge restarts the watchdog count from zero.
// (R10) Processor must toggle kick within every watchdog period.
// (R11) Grounded watchdog timing disables the watchdog entirely.
// (R12) Four-bit mode picks one of sixteen threshold sets for inputs 1-4.
// (R13) Inputs five and six always compare against 0.5 V.
// (R14) Reset stays low until threshold setup completes.
// (R15) Setup of 150 us samples the mode once, then monitoring starts.
// (R16) With watchdog grounded, reset events force fault high for good.
// (R17) Internal supply loss repeats the setup and mode sampling.
// (R18) Delays are parameterised cycle counters; mode latched as 4 bits.
//
// The address map and register access over Wishbone are this design's own decisions.
module ssw_supervisor #(
  parameter int SETUP_CYC   = ssw_pkg::SETUP_CYC,
  parameter int RST_MIN_CYC = ssw_pkg::RST_MIN_CYC,
  parameter int WD_MIN_CYC  = ssw_pkg::WD_MIN_CYC,
  parameter int RST_CYC_PF  = ssw_pkg::RST_CYC_PF,
  parameter int WD_CYC_PF   = ssw_pkg::WD_CYC_PF
) (
  // Clock and reset.
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Supervised supplies and configuration.
  input  wire logic [5:0][15:0]  monitored_supply_i,
  input  wire logic [3:0]        threshold_select_i,
  input  wire logic              vcc_ok_i,
  input  wire logic              watchdog_kick_i,
  // Supervisor outputs.
  output logic [5:0]             supply_good_o,
  output logic                   reset_n_o,
  output logic                   watchdog_fault_n_o,
  output logic                   irq_o,
  // Wishbone slave.
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o
);
  localparam logic [15:0] THR [16][4] = '{
    '{ssw_pkg::MV_5000, ssw_pkg::MV_3300, ssw_pkg::MV_HALF, ssw_pkg::MV_HALF},
    '{ssw_pkg::MV_5000, ssw_pkg::MV_3300, ssw_pkg::MV_HALF, ssw_pkg::MV_NEG},
    '{ssw_pkg::MV_3300, ssw_pkg::MV_2500, ssw_pkg::MV_HALF, ssw_pkg::MV_HALF},
    '{ssw_pkg::MV_3300, ssw_pkg::MV_2500, ssw_pkg::MV_HALF, ssw_pkg::MV_NEG},
    '{ssw_pkg::MV_3300, ssw_pkg::MV_2500, ssw_pkg::MV_1500, ssw_pkg::MV_HALF},
    '{ssw_pkg::MV_5000, ssw_pkg::MV_3300, ssw_pkg::MV_2500, ssw_pkg::MV_HALF},
    '{ssw_pkg::MV_5000, ssw_pkg::MV_3300, ssw_pkg::MV_2500, ssw_pkg::MV_1800},
    '{ssw_pkg::MV_5000, ssw_pkg::MV_3300, ssw_pkg::MV_2500, ssw_pkg::MV_1500},
    '{ssw_pkg::MV_5000, ssw_pkg::MV_3000, ssw_pkg::MV_2500, ssw_pkg::MV_HALF},
    '{ssw_pkg::MV_5000, ssw_pkg::MV_3000, ssw_pkg::MV_HALF, ssw_pkg::MV_HALF},
    '{ssw_pkg::MV_3300, ssw_pkg::MV_2500, ssw_pkg::MV_1800, ssw_pkg::MV_1500},
    '{ssw_pkg::MV_3300, ssw_pkg::MV_2500, ssw_pkg::MV_1800, ssw_pkg::MV_HALF},
    '{ssw_pkg::MV_3300, ssw_pkg::MV_2500, ssw_pkg::MV_1800, ssw_pkg::MV_NEG},
    '{ssw_pkg::MV_5000, ssw_pkg::MV_3300, ssw_pkg::MV_1800, ssw_pkg::MV_NEG},
    '{ssw_pkg::MV_5000, ssw_pkg::MV_3300, ssw_pkg::MV_1800, ssw_pkg::MV_HALF},
    '{ssw_pkg::MV_5000, ssw_pkg::MV_3000, ssw_pkg::MV_1800, ssw_pkg::MV_HALF}
  };

  // Byte-lane merge for register writes.
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] dat,
                                             input logic [3:0]  sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (dat & m);
  endfunction

  ssw_pkg::ssw_state_t state;
  ssw_pkg::ssw_state_t next_state;
  logic [31:0]            cnt;
  logic [3:0]             mode;
  logic                   configured;
  logic [5:0]             cmp_good;
  logic                   all_good;
  logic                   wd_gnd;
  logic [15:0]            rst_cap;
  logic [15:0]            wd_cap;
  logic [31:0]            rst_limit;
  logic [31:0]            wd_limit;
  logic [31:0]            wd_cnt;
  logic                   kick_q;
  logic                   kick_edge;
  logic [ssw_pkg::NUM_EV-1:0] irq_status;
  logic [ssw_pkg::NUM_EV-1:0] irq_en;
  logic [ssw_pkg::NUM_EV-1:0] irq_clr;
  logic [ssw_pkg::NUM_EV-1:0] ev;
  logic                   next_wdo_n;
  logic                   wb_req;
  logic                   wb_wr;
  logic [31:0]            ctrl_wr;
  logic [31:0]            rcap_wr;
  logic [31:0]            wcap_wr;
  logic [31:0]            en_wr;

  // Comparators; a negative adjustable input is good once it goes below 0 V.
  generate
    for (genvar i = 0; i < 6; i++) begin : g_cmp
      if (i < 4) begin : g_sel
        assign cmp_good[i] = ssw_pkg::NEG_MODES[mode] && (i == 3)
          ? $signed(monitored_supply_i[i]) < $signed(ssw_pkg::MV_NEG)
          : $signed(monitored_supply_i[i]) > $signed(THR[mode][i]); // see (R12)
      end else begin : g_fixed
        assign cmp_good[i] =
          $signed(monitored_supply_i[i]) > $signed(ssw_pkg::MV_HALF); // see (R13)
      end
    end
  endgenerate
  assign all_good  = &cmp_good;
  assign kick_edge = watchdog_kick_i ^ kick_q; // see (R9)

  // Good outputs are forced low until the comparators are enabled.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      supply_good_o <= 6'h00;
    end else begin
      supply_good_o <= cmp_good; // see (R1)
      if (next_state == ssw_pkg::SSW_SETUP) begin
        supply_good_o <= 6'h00; // see (R14)
      end
    end
  end

  // Timing limits from the programmed capacitance, one register stage.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_limit <= 32'(RST_MIN_CYC);
      wd_limit  <= 32'(WD_MIN_CYC);
    end else begin
      rst_limit <= 32'(RST_MIN_CYC) + 32'(rst_cap) * 32'(RST_CYC_PF); // see (R3)
      wd_limit  <= 32'(WD_MIN_CYC) + 32'(wd_cap) * 32'(WD_CYC_PF); // see (R4)
    end
  end

  // Sequencer next state.
  always_comb begin
    next_state = state;
    case (state)
      ssw_pkg::SSW_SETUP: begin
        if (vcc_ok_i && cnt + 32'h1 >= 32'(SETUP_CYC)) begin
          next_state = ssw_pkg::SSW_HOLD; // see (R15)
        end
      end
      ssw_pkg::SSW_HOLD: begin
        if (all_good) begin
          next_state = ssw_pkg::SSW_DELAY;
        end
      end
      ssw_pkg::SSW_DELAY: begin
        if (!all_good) begin
          next_state = ssw_pkg::SSW_HOLD;
        end else if (cnt + 32'h1 >= rst_limit) begin
          next_state = ssw_pkg::SSW_RUN; // see (R2)
        end
      end
      ssw_pkg::SSW_RUN: begin
        if (!all_good) begin
          next_state = ssw_pkg::SSW_HOLD; // see (R2)
        end
      end
      default: next_state = ssw_pkg::SSW_SETUP;
    endcase
    if (!vcc_ok_i) begin
      next_state = ssw_pkg::SSW_SETUP; // see (R17)
    end
  end

  // Sequencer state, counter, mode latch and reset output.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state      <= ssw_pkg::SSW_SETUP;
      cnt        <= 32'h0000_0000;
      mode       <= 4'h0;
      configured <= 1'b0;
      reset_n_o  <= 1'b0;
    end else begin
      state     <= next_state;
      reset_n_o <= (next_state == ssw_pkg::SSW_RUN); // see (R14)
      if (state == ssw_pkg::SSW_SETUP && vcc_ok_i && cnt == 32'h0) begin
        mode <= threshold_select_i; // see (R18)
      end
      configured <= (next_state != ssw_pkg::SSW_SETUP);
      if (next_state != state || !vcc_ok_i) begin
        cnt <= 32'h0000_0000;
      end else if (state == ssw_pkg::SSW_SETUP
                   || state == ssw_pkg::SSW_DELAY) begin
        cnt <= cnt + 32'h1;
      end
    end
  end

  // Watchdog next fault level; one counter times both phases of the toggle.
  always_comb begin
    next_wdo_n = watchdog_fault_n_o;
    if (!reset_n_o || wd_gnd || kick_edge) begin
      next_wdo_n = 1'b1; // see (R7) (R16)
    end else if (watchdog_fault_n_o && wd_cnt + 32'h1 >= wd_limit) begin
      next_wdo_n = 1'b0; // see (R6)
    end else if (!watchdog_fault_n_o && wd_cnt + 32'h1 >= rst_limit) begin
      next_wdo_n = 1'b1; // see (R8)
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_cnt             <= 32'h0000_0000;
      watchdog_fault_n_o <= 1'b1;
      kick_q             <= 1'b1;
    end else begin
      kick_q             <= watchdog_kick_i;
      watchdog_fault_n_o <= next_wdo_n;
      if (!reset_n_o || wd_gnd || kick_edge) begin
        wd_cnt <= 32'h0000_0000; // see (R5) (R9) (R11)
      end else if (next_wdo_n != watchdog_fault_n_o) begin
        wd_cnt <= 32'h0000_0000; // see (R8)
      end else begin
        wd_cnt <= wd_cnt + 32'h1;
      end
    end
  end

  // Events and interrupt; a new event beats a clear in the same cycle.
  assign ev[ssw_pkg::EV_RST_ASSERT] = reset_n_o && next_state != ssw_pkg::SSW_RUN;
  assign ev[ssw_pkg::EV_WD_FAULT]   = watchdog_fault_n_o && !next_wdo_n;
  assign ev[ssw_pkg::EV_RST_FREE]   = !reset_n_o && next_state == ssw_pkg::SSW_RUN;
  assign ev[ssw_pkg::EV_DROP]       = |(supply_good_o & ~cmp_good) && configured;
  assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr   = wb_req && wb_we_i;
  assign irq_clr = (wb_wr && wb_adr_i == ssw_pkg::ADR_IRQ_CLR)
                   ? wb_dat_i[ssw_pkg::NUM_EV-1:0] & {ssw_pkg::NUM_EV{wb_sel_i[0]}}
                   : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= '0;
      irq_o      <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | ev;
      irq_o      <= |(((irq_status & ~irq_clr) | ev) & irq_en);
    end
  end

  // Lanes are merged ahead of the flops so each write takes a plain slice.
  assign ctrl_wr = lane_merge({31'h0, wd_gnd}, wb_dat_i, wb_sel_i);
  assign rcap_wr = lane_merge({16'h0, rst_cap}, wb_dat_i, wb_sel_i);
  assign wcap_wr = lane_merge({16'h0, wd_cap}, wb_dat_i, wb_sel_i);
  assign en_wr   = lane_merge({28'h0, irq_en}, wb_dat_i, wb_sel_i);

  // Register writes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_gnd  <= 1'b0;
      rst_cap <= ssw_pkg::CAP_RESET;
      wd_cap  <= ssw_pkg::CAP_RESET;
      irq_en  <= '0;
    end else if (wb_wr) begin
      if (wb_adr_i == ssw_pkg::ADR_CTRL) begin
        wd_gnd <= ctrl_wr[ssw_pkg::CTRL_WD_GND]; // see (R11)
      end else if (wb_adr_i == ssw_pkg::ADR_RST_CAP) begin
        rst_cap <= rcap_wr[15:0];
      end else if (wb_adr_i == ssw_pkg::ADR_WD_CAP) begin
        wd_cap <= wcap_wr[15:0];
      end else if (wb_adr_i == ssw_pkg::ADR_IRQ_EN) begin
        irq_en <= en_wr[ssw_pkg::NUM_EV-1:0];
      end
    end
  end

  // Read data and acknowledge; every access is answered in the next cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
        if (wb_adr_i == ssw_pkg::ADR_CTRL) begin
          wb_dat_o <= {31'h0, wd_gnd};
        end else if (wb_adr_i == ssw_pkg::ADR_RST_CAP) begin
          wb_dat_o <= {16'h0, rst_cap};
        end else if (wb_adr_i == ssw_pkg::ADR_WD_CAP) begin
          wb_dat_o <= {16'h0, wd_cap};
        end else if (wb_adr_i == ssw_pkg::ADR_STATUS) begin
          wb_dat_o <= {12'h0, mode, 2'h0, supply_good_o, 5'h0, configured,
                       watchdog_fault_n_o, reset_n_o};
        end else if (wb_adr_i == ssw_pkg::ADR_IRQ_ST) begin
          wb_dat_o <= {28'h0, irq_status};
        end else if (wb_adr_i == ssw_pkg::ADR_IRQ_EN) begin
          wb_dat_o <= {28'h0, irq_en};
        end
      end
    end
  end

  // Checks on the supervisor behaviour.
  good_follow_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (R1)
    configured && $past(configured) |-> supply_good_o == $past(cmp_good))
    else $error("good output does not follow comparator");
  reset_on_drop_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (R2)
    configured && !all_good |=> !reset_n_o)
    else $error("reset not asserted on bad supply");
  release_delay_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (R3)
    $rose(reset_n_o) |-> $past(state) == ssw_pkg::SSW_DELAY
                         && $past(cnt) + 32'h1 >= $past(rst_limit))
    else $error("reset released before delay");
  wd_expiry_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (R4)
    $fell(watchdog_fault_n_o) |-> $past(wd_cnt) + 32'h1 >= $past(wd_limit))
    else $error("watchdog fault before period");
  wd_cleared_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (R5)
    !reset_n_o |=> wd_cnt == 32'h0 && watchdog_fault_n_o)
    else $error("watchdog not cleared in reset");
  fault_length_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (R6)
    $rose(watchdog_fault_n_o) && $past(reset_n_o) && !$past(kick_edge)
    && !$past(wd_gnd) |-> $past(wd_cnt) + 32'h1 >= $past(rst_limit))
    else $error("fault pulse ended early");
  fault_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (R7)
    (kick_edge || !reset_n_o) |=> watchdog_fault_n_o)
    else $error("fault not released on kick or reset");
  kick_restart_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (R9)
    kick_edge |=> wd_cnt == 32'h0)
    else $error("kick did not restart watchdog");
  wd_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (R11)
    wd_gnd ##1 wd_gnd |-> watchdog_fault_n_o && wd_cnt == 32'h0)
    else $error("disabled watchdog reported fault");
  setup_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (R14)
    !configured |-> !reset_n_o && supply_good_o == 6'h00)
    else $error("reset released before setup");
  mode_once_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (R15)
    configured && $past(configured) |-> $stable(mode))
    else $error("mode changed after setup");
  vcc_loss_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (R17)
    !vcc_ok_i |=> state == ssw_pkg::SSW_SETUP && !reset_n_o)
    else $error("supply loss did not restart setup");
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  release_c: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(reset_n_o));
  fault_c: cover property (@(posedge clk_i) disable iff (rst_i)
    $fell(watchdog_fault_n_o));
  toggle_c: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(watchdog_fault_n_o) && reset_n_o && !kick_edge);
  kick_c: cover property (@(posedge clk_i) disable iff (rst_i)
    reset_n_o && kick_edge && !watchdog_fault_n_o);
endmodule // ssw_supervisor

// file: dv/ssw_cpu_model.sv
// Processor stand-in that receives reset and services the watchdog kick.
// Assumes the bench switches servicing on and off through service_i.
module ssw_cpu_model #(
  parameter int PERIOD = 10
) (
  // Clock.
  input  wire logic clk_i,
  // Supervisor output and bench control.
  input  wire logic reset_n_i,
  input  wire logic service_i,
  // Kick output; idles high like a pulled-up pin, so reset sees no edge.
  output logic      kick_o = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;

  // A processor held in reset runs no code, so it kicks only when free.
  always_ff @(posedge clk_i) begin
    if (reset_n_i && service_i) begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      if (cnt == 0) kick_o <= ~kick_o;
    end else begin
      cnt <= 0;
    end
  end
endmodule // ssw_cpu_model

// file: dv/supply_supervisor_watchdog_test.sv
// Self-checking bench for the supply supervisor and watchdog.
// Assumes the design packages are compiled first; uses shortened counts.
module supply_supervisor_watchdog_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SETUP = 20;
  localparam int RMIN  = 10;
  localparam int WMIN  = 30;
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic [5:0][15:0] supply = '0;
  logic [3:0]       mode = 4'h0;
  logic             vcc_ok = 1'b0;
  logic             service = 1'b0;
  logic             kick;
  logic [5:0]       good;
  logic             reset_n, fault_n, irq, ack;
  logic             cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]       adr = 8'h00;
  logic [31:0]      wdat = 32'h0, rdat, q;
  int               miscompares = 0, cmp_count = 0, n;
  // Thresholds in millivolts for inputs one to four; zero marks negative.
  logic [15:0] thr [3][4] = '{'{16'h1388, 16'h0CE4, 16'h09C4, 16'h0708},
                              '{16'h0CE4, 16'h09C4, 16'h0708, 16'h0000},
                              '{16'h1388, 16'h0BB8, 16'h0708, 16'h01F4}};
  logic [3:0]  modes [3] = '{4'h6, 4'hC, 4'hF};

  always #2 clk_i = ~clk_i;

  ssw_supervisor #(.SETUP_CYC(SETUP), .RST_MIN_CYC(RMIN), .WD_MIN_CYC(WMIN),
    .RST_CYC_PF(1), .WD_CYC_PF(2)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .monitored_supply_i(supply), .threshold_select_i(mode),
    .vcc_ok_i(vcc_ok), .watchdog_kick_i(kick), .supply_good_o(good),
    .reset_n_o(reset_n), .watchdog_fault_n_o(fault_n), .irq_o(irq),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
  ssw_cpu_model #(.PERIOD(10)) cpu (.clk_i(clk_i), .reset_n_i(reset_n),
    .service_i(service), .kick_o(kick));

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask

  task automatic span(input int v, lo, hi, input string what);
    check(32'(v >= lo && v <= hi), 32'h1, what);
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask

  // Waits on reset (0), fault (1) or interrupt (2) and counts the cycles.
  task automatic wait_sig(input int s, input logic v, output int k);
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
      if (k > 3000) begin
        check(32'h0, 32'h1, "wait bound");
        report_and_stop();
      end
    end while ((s == 0 ? reset_n : s == 1 ? fault_n : irq) !== v);
  endtask

  // One classic cycle; ack and read data are taken at one rising edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
      if (k > 50) begin
        check(32'h0, 32'h1, "bus ack bound");
        report_and_stop();
      end
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // Inputs just above threshold (just below 0 V for a negative input), except input lo sitting exactly on it.
  task automatic drive(input int m, lo);
    logic [5:0][15:0] v;
    logic [15:0]      t;
    for (int i = 0; i < 6; i++) begin
      t = (i > 3) ? 16'h01F4 : thr[m][i];
      if (t == 16'h0000)
        v[i] = (i == lo) ? 16'h0000 : 16'hFFFF;
      else
        v[i] = (i == lo) ? t : t + 16'h0001;
    end
    @(posedge clk_i);
    supply <= v;
  endtask

  task automatic configure(input int m);
    drive(m, 6);
    vcc_ok <= 1'b0;
    mode <= modes[m];
    tick(2);
    vcc_ok <= 1'b1;
    tick(SETUP / 2);
    @(negedge clk_i);
    check(reset_n, 1'b0, "reset during setup");
    tick(SETUP + RMIN + 6);
    wb(1'b0, 8'h0C, 32'h0);
    check(q[19:16], modes[m], "sampled mode");
    check(q[2:0], 3'h7, "configured and released");
    mode <= ~modes[m];
    wb(1'b0, 8'h0C, 32'h0);
    check(q[19:16], modes[m], "mode change after setup");
  endtask

  initial begin
    tick(5);
    rst_i <= 1'b0;
    wb(1'b0, 8'h18, 32'h0);
    check(q, 32'h0, "irq enable at reset");
    wb(1'b1, 8'h40, 32'hFFFF_FFFF);
    wb(1'b0, 8'h40, 32'h0);
    check(q, 32'h0, "unmapped read");
    $display("test registers done");
    for (int m = 0; m < 3; m++) begin
      configure(m);
      for (int i = 0; i < 6; i++) begin
        drive(m, i);
        tick(2);
        @(negedge clk_i);
        check(good, 6'h3F & ~(6'h01 << i), "good");
        check(reset_n, 1'b0, "reset on low input");
      end
      drive(m, 6);
    end
    $display("test thresholds done");
    wb(1'b1, 8'h04, 32'h2);
    wb(1'b1, 8'h08, 32'h1);
    wb(1'b1, 8'h18, 32'h2);
    drive(2, 0);
    tick(3);
    drive(2, 6);
    wait_sig(0, 1'b1, n);
    span(n, 13, 16, "reset delay");
    wait_sig(1, 1'b0, n);
    span(n, 31, 36, "watchdog period");
    wait_sig(1, 1'b1, n);
    span(n, 11, 15, "fault pulse");
    wait_sig(1, 1'b0, n);
    span(n, 31, 36, "repeated period");
    @(posedge clk_i);
    service <= 1'b1;
    wait_sig(1, 1'b1, n);
    span(n, 1, 5, "kick clears fault");
    n = 0;
    repeat (300) begin
      @(negedge clk_i);
      if (fault_n !== 1'b1) n++;
    end
    check(n, 0, "fault while serviced");
    $display("test watchdog done");
    check(irq, 1'b1, "irq after fault");
    wb(1'b1, 8'h14, 32'hF);
    @(negedge clk_i);
    check(irq, 1'b0, "irq cleared");
    wb(1'b1, 8'h18, 32'h0);
    @(posedge clk_i);
    service <= 1'b0;
    wait_sig(1, 1'b0, n);
    tick(2);
    @(negedge clk_i);
    check(irq, 1'b0, "irq masked");
    drive(2, 0);
    wait_sig(1, 1'b1, n);
    span(n, 1, 4, "reset low clears fault");
    wb(1'b0, 8'h10, 32'h0);
    check(q[1], 1'b1, "fault event sticky");
    check(q[3:0], 4'hB, "events since clear");
    $display("test interrupts done");
    wb(1'b1, 8'h00, 32'h1);
    drive(2, 6);
    n = 0;
    repeat (400) begin
      @(negedge clk_i);
      if (fault_n !== 1'b1) n++;
    end
    check(n, 0, "grounded watchdog");
    wb(1'b0, 8'h10, 32'h0);
    check(q[2], 1'b1, "release event");
    $display("test grounded done");
    report_and_stop();
  end
endmodule // supply_supervisor_watchdog_test
